// file: rtl/bmc_phy.v
/*
 baseband BMC phy for the Type-C configuration channel: transmit with
 preamble and closing edge, receive with edge-interval decoding, squelch,
 CC pin selection and dead-battery supply switch gating.
 assumes CC inputs already synchronous to MCLK; the framing layer above
 supplies encoded bits (preamble excluded) and marks the last one.
*/
// Contract
// - transition each cell start; ones add mid-cell
// - preamble begins by driving low level
// - receiver tolerates lost first preamble edge
// - closing edge after final end-of-packet bit
// - drive CC only while transmitting, else Hi-Z
// - one CC pin fixed for whole connection
// - single talker; others present high impedance
// - active after NCOUNT transitions within window
// - idle after full window without NCOUNT
// - squelch follows line, including own transmitter
// - supply switch open until dead-battery flag cleared
`timescale 1ns/1ps
`include "bmc_phy_consts.vh"
module bmc_phy #(
  parameter FIFO_DEPTH = 32,
  parameter FIFO_AW = 5,
  parameter NCOUNT = `NCOUNT,
  parameter WIN_CYC = `TTRANWIN_CYC,
  parameter UI_CYC = `UI_CYC
) (
  // clock and reset
  input wire MCLK,
  input wire RST,
  // connection control
  input wire ATTACHED,
  input wire ORIENT_CC2,
  // transmit bit stream
  input wire TX_VALID,
  output wire TX_READY,
  input wire TX_BIT,
  input wire TX_LAST,
  output wire TX_BUSY,
  // receive bit stream
  output wire RX_VALID,
  input wire RX_READY,
  output wire RX_BIT,
  output reg RX_OVERRUN,
  // squelch
  output reg LINE_ACTIVE,
  // dead battery
  input wire DEAD_BATT_AT_BOOT,
  input wire DEAD_BATT_CLEAR,
  output reg DEAD_BATT_FLAG,
  output reg MAIN_SUPPLY_INPUT_CLOSED,
  // CC pins, oe low while driving
  input wire CC1_I,
  output reg CC1_O,
  output reg CC1_OE_N,
  input wire CC2_I,
  output reg CC2_O,
  output reg CC2_OE_N
);

  // ***************
  // connection / pin select
  // ***************
  reg sel_q;
  reg lock_q;
  always @(posedge MCLK) begin
    if (RST) begin
      sel_q <= 1'b0;
      lock_q <= 1'b0;
    end else if (!ATTACHED) begin
      lock_q <= 1'b0;
    end else if (!lock_q) begin
      sel_q <= ORIENT_CC2;
      lock_q <= 1'b1;
    end
  end
  wire sel_cc = lock_q ? sel_q : ORIENT_CC2;
  wire cc_in = sel_cc ? CC2_I : CC1_I;

  // ***************
  // transmit
  // ***************
  localparam TX_IDLE = 4'b0001;
  localparam TX_PRE = 4'b0010;
  localparam TX_DATA = 4'b0100;
  localparam TX_END = 4'b1000;

  wire fo_valid;
  wire fo_bit;
  wire fo_last;
  reg fo_pop;
  wire [1:0] fo_data;

  bmc_fifo #(.WIDTH(2), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_txfifo (
    .clk(MCLK),
    .rst(RST),
    .in_valid(TX_VALID),
    .in_ready(TX_READY),
    .in_data({TX_LAST, TX_BIT}),
    .out_valid(fo_valid),
    .out_ready(fo_pop),
    .out_data(fo_data),
    .full(),
    .empty()
  );
  assign fo_bit = fo_data[0];
  assign fo_last = fo_data[1];

  reg [3:0] tx_st_q;
  reg [15:0] tx_cnt_q;
  reg [6:0] pre_q;
  reg cur_bit_q;
  reg cur_last_q;
  reg line_q;
  wire cell_end = (tx_cnt_q == UI_CYC - 1);
  wire half = (tx_cnt_q == (UI_CYC / 2) - 1);
  wire drive = (tx_st_q != TX_IDLE);

  always @(*) begin
    fo_pop = 1'b0;
    if ((tx_st_q == TX_PRE && cell_end && pre_q == `PREAMBLE_BITS - 1) ||
        (tx_st_q == TX_DATA && cell_end && !cur_last_q)) begin
      fo_pop = fo_valid;
    end
  end

  always @(posedge MCLK) begin
    if (RST) begin
      tx_st_q <= TX_IDLE;
      tx_cnt_q <= 16'h0000;
      pre_q <= 7'h00;
      cur_bit_q <= 1'b0;
      cur_last_q <= 1'b0;
      line_q <= 1'b1;
    end else begin
      case (tx_st_q)
        TX_IDLE: begin
          tx_cnt_q <= 16'h0000;
          pre_q <= 7'h00;
          line_q <= 1'b1;
          if (fo_valid && ATTACHED && !LINE_ACTIVE) begin
            tx_st_q <= TX_PRE;
            line_q <= 1'b0;
          end
        end
        TX_PRE: begin
          // preamble is alternating 0/1 starting with 0
          tx_cnt_q <= cell_end ? 16'h0000 : tx_cnt_q + 16'h0001;
          if (half && pre_q[0]) begin
            line_q <= ~line_q;
          end
          if (cell_end) begin
            line_q <= ~line_q;
            pre_q <= pre_q + 7'h01;
            if (pre_q == `PREAMBLE_BITS - 1) begin
              if (fo_valid) begin
                cur_bit_q <= fo_bit;
                cur_last_q <= fo_last;
                tx_st_q <= TX_DATA;
              end else begin
                tx_st_q <= TX_END;
              end
            end
          end
        end
        TX_DATA: begin
          tx_cnt_q <= cell_end ? 16'h0000 : tx_cnt_q + 16'h0001;
          if (half && cur_bit_q) begin
            line_q <= ~line_q;
          end
          if (cell_end) begin
            line_q <= ~line_q;
            if (cur_last_q || !fo_valid) begin
              tx_st_q <= TX_END;
            end else begin
              cur_bit_q <= fo_bit;
              cur_last_q <= fo_last;
            end
          end
        end
        TX_END: begin
          // hold the closing edge half a cell, then release
          tx_cnt_q <= tx_cnt_q + 16'h0001;
          if (half) begin
            tx_st_q <= TX_IDLE;
            line_q <= 1'b1;
          end
        end
        default: tx_st_q <= TX_IDLE;
      endcase
    end
  end
  assign TX_BUSY = drive;

  always @(posedge MCLK) begin
    if (RST) begin
      CC1_O <= 1'b0;
      CC2_O <= 1'b0;
      CC1_OE_N <= 1'b1;
      CC2_OE_N <= 1'b1;
    end else begin
      CC1_O <= line_q;
      CC2_O <= line_q;
      CC1_OE_N <= ~(drive && !sel_cc);
      CC2_OE_N <= ~(drive && sel_cc);
    end
  end

  // ***************
  // receive
  // ***************
  reg cc_d_q;
  reg [15:0] rx_cnt_q;
  reg rx_sync_q;
  reg half_seen_q;
  reg rx_push;
  reg rx_val;
  wire edge_in = (cc_in != cc_d_q);
  wire rx_ready_in;

  always @(posedge MCLK) begin
    if (RST) begin
      cc_d_q <= 1'b1;
      rx_cnt_q <= 16'h0000;
      rx_sync_q <= 1'b0;
      half_seen_q <= 1'b0;
      rx_push <= 1'b0;
      rx_val <= 1'b0;
    end else begin
      cc_d_q <= cc_in;
      rx_push <= 1'b0;
      if (edge_in) begin
        rx_cnt_q <= 16'h0000;
        if (!rx_sync_q) begin
          // any first edge seen starts timing, so a lost leading edge is harmless
          rx_sync_q <= 1'b1;
          half_seen_q <= 1'b0;
        end else if (rx_cnt_q < `RX_SPLIT_CYC) begin
          if (half_seen_q) begin
            rx_push <= 1'b1;
            rx_val <= 1'b1;
            half_seen_q <= 1'b0;
          end else begin
            half_seen_q <= 1'b1;
          end
        end else begin
          rx_push <= 1'b1;
          rx_val <= 1'b0;
          half_seen_q <= 1'b0;
        end
      end else begin
        rx_cnt_q <= (rx_cnt_q == 16'hFFFF) ? rx_cnt_q : rx_cnt_q + 16'h0001;
        if (rx_cnt_q >= `RX_TIMEOUT_CYC) begin
          rx_sync_q <= 1'b0;
          half_seen_q <= 1'b0;
        end
      end
    end
  end

  bmc_fifo #(.WIDTH(1), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_rxfifo (
    .clk(MCLK),
    .rst(RST),
    .in_valid(rx_push && !drive),
    .in_ready(rx_ready_in),
    .in_data(rx_val),
    .out_valid(RX_VALID),
    .out_ready(RX_READY),
    .out_data(RX_BIT),
    .full(),
    .empty()
  );

  always @(posedge MCLK) begin
    if (RST) begin
      RX_OVERRUN <= 1'b0;
    end else if (rx_push && !drive && !rx_ready_in) begin
      RX_OVERRUN <= 1'b1;
    end else if (!rx_sync_q) begin
      RX_OVERRUN <= 1'b0;
    end
  end

  // ***************
  // squelch
  // ***************
  reg [15:0] win_q;
  reg [7:0] tcnt_q;
  always @(posedge MCLK) begin
    if (RST) begin
      win_q <= 16'h0000;
      tcnt_q <= 8'h00;
      LINE_ACTIVE <= 1'b0;
    end else begin
      // own transmitter edges count too, cc_in is the pad
      if (win_q == WIN_CYC - 1) begin
        win_q <= 16'h0000;
        tcnt_q <= 8'h00;
        if (tcnt_q + (edge_in ? 8'h01 : 8'h00) < NCOUNT) begin
          LINE_ACTIVE <= 1'b0;
        end
      end else begin
        win_q <= win_q + 16'h0001;
        if (edge_in && tcnt_q != 8'hFF) begin
          tcnt_q <= tcnt_q + 8'h01;
        end
      end
      if (edge_in && tcnt_q + 8'h01 >= NCOUNT) begin
        LINE_ACTIVE <= 1'b1;
      end
    end
  end

  // ***************
  // dead battery
  // ***************
  reg boot_q;
  always @(posedge MCLK) begin
    if (RST) begin
      boot_q <= 1'b1;
      DEAD_BATT_FLAG <= 1'b0;
      MAIN_SUPPLY_INPUT_CLOSED <= 1'b0;
    end else begin
      boot_q <= 1'b0;
      if (boot_q) begin
        DEAD_BATT_FLAG <= DEAD_BATT_AT_BOOT;
        MAIN_SUPPLY_INPUT_CLOSED <= ~DEAD_BATT_AT_BOOT;
      end else if (DEAD_BATT_CLEAR) begin
        DEAD_BATT_FLAG <= 1'b0;
        MAIN_SUPPLY_INPUT_CLOSED <= 1'b1;
      end
    end
  end

endmodule // bmc_phy

// file: rtl/bmc_phy_consts.vh
/*
 constants for the baseband BMC phy: bit timing, squelch window, preamble.
 assumes a 100 MHz core clock (10 ns period).
*/
`ifndef BMC_PHY_CONSTS_VH
`define BMC_PHY_CONSTS_VH

// ***************
// clock
// ***************
`define CLK_PERIOD_NS 10

// ***************
// bit timing
// ***************
// unit interval in ns (300 kbit/s nominal)
`define UI_NS 3333
`define UI_CYC ((`UI_NS) / (`CLK_PERIOD_NS))
`define HALF_UI_CYC ((`UI_NS) / (2 * (`CLK_PERIOD_NS)))
// receive: an interval shorter than this is a half cell
`define RX_SPLIT_CYC (((`UI_NS) * 3) / (4 * (`CLK_PERIOD_NS)))
// receive: an interval longer than this ends the packet
`define RX_TIMEOUT_CYC (((`UI_NS) * 2) / (`CLK_PERIOD_NS))

// ***************
// preamble
// ***************
`define PREAMBLE_BITS 64

// ***************
// squelch
// ***************
`define NCOUNT 3
`define TTRANWIN_NS 20000
`define TTRANWIN_CYC ((`TTRANWIN_NS) / (`CLK_PERIOD_NS))

`endif

// file: rtl/bmc_fifo.v
/*
 synchronous valid/ready FIFO with parameter width and depth.
 assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module bmc_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // drain side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data,
  // state
  output wire full,
  output wire empty
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  wire push;
  wire pop;

  assign full = (cnt_q == DEPTH[AW:0]);
  assign empty = (cnt_q == {(AW+1){1'b0}});
  assign in_ready = ~full;
  assign out_valid = ~empty;
  assign out_data = mem[rd_q];
  assign push = in_valid & ~full;
  assign pop = out_ready & ~empty;

  always @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
      end
      case ({push, pop})
        2'b10: cnt_q <= cnt_q + 1'b1;
        2'b01: cnt_q <= cnt_q - 1'b1;
        default: cnt_q <= cnt_q;
      endcase
    end
  end

endmodule // bmc_fifo

// file: tb/bmc_far_port.sv
/*
 far PD port model: sends one BMC frame on the CC wire, else Hi-Z.
 assumes the bench calls send at a falling edge while the line is idle.
*/
`timescale 1ns/1ps
module bmc_far_port (
  // clock
  input wire clk,
  // line drive, oe low while driving
  output reg o,
  output reg oe_n
);
  // ***************
  // frame sender
  // ***************
  initial begin
    o = 1'b0;
    oe_n = 1'b1;
  end
  // lose set: first level equals the bias, so the first edge is missing
  task send(input [15:0] d, input integer n, input lose);
    integer i;
    reg b;
    begin
      oe_n = 1'b0;
      o = lose;
      for (i = 0; i < 64 + n; i = i + 1) begin
        b = (i < 64) ? i[0] : d[i - 64];
        if (i > 0) o = ~o;
        repeat (166) @(negedge clk);
        if (b) o = ~o;
        repeat (167) @(negedge clk);
      end
      o = ~o;
      repeat (166) @(negedge clk);
      oe_n = 1'b1;
    end
  endtask
endmodule // bmc_far_port

// file: tb/bmc_phy_props.sv
/*
 assertions on the bmc_phy top ports.
 assumes ORIENT_CC2 is held while ATTACHED and the idle pin stays constant.
*/
`timescale 1ns/1ps
module bmc_phy_props #(
  parameter UI_CYC = 333,
  parameter WIN_CYC = 2000
) (
  // clock and reset
  input wire MCLK,
  input wire RST,
  // observed ports
  input wire ATTACHED,
  input wire ORIENT_CC2,
  input wire TX_READY,
  input wire TX_BUSY,
  input wire RX_VALID,
  input wire LINE_ACTIVE,
  input wire DEAD_BATT_CLEAR,
  input wire DEAD_BATT_FLAG,
  input wire MAIN_SUPPLY_INPUT_CLOSED,
  input wire CC1_I,
  input wire CC1_O,
  input wire CC1_OE_N,
  input wire CC2_I,
  input wire CC2_O,
  input wire CC2_OE_N
);
  // ***************
  // run lengths of drive level and line level
  // ***************
  wire drv = !(CC1_OE_N && CC2_OE_N);
  wire lvl = CC2_OE_N ? CC1_O : CC2_O;
  wire line = CC1_I ^ CC2_I;
  reg lvl_q, line_q;
  reg [15:0] run_q, quiet_q;
  always @(posedge MCLK) begin
    lvl_q <= lvl;
    line_q <= line;
    run_q <= (!drv || lvl != lvl_q) ? 16'h0000 : run_q + 16'h0001;
    quiet_q <= (RST || line != line_q) ? 16'h0000 : quiet_q + {15'h0000, quiet_q != 16'hFFFF};
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  a_single_talker: assert property (CC1_OE_N || CC2_OE_N) else $error("both CC pins driven");
  a_pin_follows_orient: assert property (drv |-> ATTACHED && CC1_OE_N == ORIENT_CC2) else $error("wrong CC pin");
  a_idle_hiz: assert property (!TX_BUSY && $past(!TX_BUSY) |-> !drv) else $error("CC driven while idle");
  a_start_low: assert property ($rose(drv) |-> !lvl) else $error("drive began high");
  a_cell_edge: assert property (drv |-> run_q <= UI_CYC) else $error("cell without edge");
  a_edge_activates: assert property ($rose(LINE_ACTIVE) |-> quiet_q < 16'h0004) else $error("active w/o edge");
  a_quiet_idles: assert property (quiet_q > 2 * WIN_CYC + 4 |-> !LINE_ACTIVE) else $error("idle missed");
  a_flag_opens: assert property (DEAD_BATT_FLAG |-> !MAIN_SUPPLY_INPUT_CLOSED) else $error("switch closed");
  a_clear_closes: assert property (DEAD_BATT_CLEAR |-> ##[1:2] (!DEAD_BATT_FLAG && MAIN_SUPPLY_INPUT_CLOSED))
    else $error("clear ignored");
  a_reset_values: assert property ($fell(RST) |-> !drv && !LINE_ACTIVE && !RX_VALID && TX_READY)
    else $error("bad reset state");
  c_idle: cover property ($fell(LINE_ACTIVE));
  c_drive: cover property ($rose(drv));
  c_clear: cover property ($fell(DEAD_BATT_FLAG));
  c_receive: cover property ($rose(RX_VALID));
endmodule // bmc_phy_props

bind bmc_phy bmc_phy_props #(.UI_CYC(UI_CYC), .WIN_CYC(WIN_CYC)) bmc_phy_props_i (.MCLK(MCLK), .RST(RST),
  .ATTACHED(ATTACHED), .ORIENT_CC2(ORIENT_CC2), .TX_READY(TX_READY), .TX_BUSY(TX_BUSY), .RX_VALID(RX_VALID),
  .LINE_ACTIVE(LINE_ACTIVE), .DEAD_BATT_CLEAR(DEAD_BATT_CLEAR), .DEAD_BATT_FLAG(DEAD_BATT_FLAG),
  .MAIN_SUPPLY_INPUT_CLOSED(MAIN_SUPPLY_INPUT_CLOSED), .CC1_I(CC1_I), .CC1_O(CC1_O), .CC1_OE_N(CC1_OE_N),
  .CC2_I(CC2_I), .CC2_O(CC2_O), .CC2_OE_N(CC2_OE_N));

// file: tb/tb_top.sv
/*
 self-checking bench for bmc_phy: reset, dead battery, transmit, receive.
 assumes bmc_far_port on the selected CC wire; released wires pull high.
*/
`timescale 1ns/1ps
module tb_top;
  reg MCLK = 1'b0;
  reg RST = 1'b1;
  reg ATTACHED = 1'b0;
  reg ORIENT_CC2 = 1'b0;
  reg TX_VALID = 1'b0;
  reg TX_BIT = 1'b0;
  reg TX_LAST = 1'b0;
  reg RX_READY = 1'b0;
  reg DEAD_BATT_AT_BOOT = 1'b1;
  reg DEAD_BATT_CLEAR = 1'b0;
  wire TX_READY, TX_BUSY, RX_VALID, RX_BIT, RX_OVERRUN, LINE_ACTIVE, DEAD_BATT_FLAG, MAIN_SUPPLY_INPUT_CLOSED;
  wire CC1_O, CC1_OE_N, CC2_O, CC2_OE_N, far_o, far_oe_n;
  wire cc1 = !CC1_OE_N ? CC1_O : (!far_oe_n && !ORIENT_CC2) ? far_o : 1'b1;
  wire cc2 = !CC2_OE_N ? CC2_O : (!far_oe_n && ORIENT_CC2) ? far_o : 1'b1;
  wire cc = ORIENT_CC2 ? cc2 : cc1;
  integer bad_count = 0;
  integer total_checks = 0;
  integer edges = 0;
  reg [31:0] seed = 32'hF7F8151A;
  reg seen_active = 1'b0;
  reg seen_ovr = 1'b0;
  reg cc_q = 1'b1;
  reg drv_q = 1'b0;
  reg rxq[$];
  bmc_phy bmc_phy_i (.MCLK(MCLK), .RST(RST), .ATTACHED(ATTACHED), .ORIENT_CC2(ORIENT_CC2),
    .TX_VALID(TX_VALID), .TX_READY(TX_READY), .TX_BIT(TX_BIT), .TX_LAST(TX_LAST), .TX_BUSY(TX_BUSY),
    .RX_VALID(RX_VALID), .RX_READY(RX_READY), .RX_BIT(RX_BIT), .RX_OVERRUN(RX_OVERRUN),
    .LINE_ACTIVE(LINE_ACTIVE), .DEAD_BATT_AT_BOOT(DEAD_BATT_AT_BOOT), .DEAD_BATT_CLEAR(DEAD_BATT_CLEAR),
    .DEAD_BATT_FLAG(DEAD_BATT_FLAG), .MAIN_SUPPLY_INPUT_CLOSED(MAIN_SUPPLY_INPUT_CLOSED),
    .CC1_I(cc1), .CC1_O(CC1_O), .CC1_OE_N(CC1_OE_N), .CC2_I(cc2), .CC2_O(CC2_O), .CC2_OE_N(CC2_OE_N));
  bmc_far_port bmc_far_port_i (.clk(MCLK), .o(far_o), .oe_n(far_oe_n));
  always #5 MCLK = ~MCLK;
  // ***************
  // line and receive monitors
  // ***************
  always @(posedge MCLK) begin
    cc_q <= cc;
    drv_q <= !(CC1_OE_N && CC2_OE_N);
    if (drv_q && !(CC1_OE_N && CC2_OE_N) && cc !== cc_q) edges = edges + 1;
    if (LINE_ACTIVE === 1'b1) seen_active = 1'b1;
    if (RX_OVERRUN === 1'b1) seen_ovr = 1'b1;
    if (RX_VALID === 1'b1 && RX_READY) rxq.push_back(RX_BIT);
  end
  always @(negedge MCLK) RX_READY <= ~RX_READY;
  function [31:0] nxt;
    begin
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      nxt = seed;
    end
  endfunction
  task chk(input string what, input [31:0] seen, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
      end
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  task wait_idle(input integer lim);
    integer k;
    begin
      k = 0;
      while ((LINE_ACTIVE !== 1'b0 || TX_BUSY !== 1'b0 || far_oe_n !== 1'b1) && k < lim) begin
        @(negedge MCLK);
        k = k + 1;
      end
      if (k >= lim) begin
        chk("idle wait", 0, 1);
        tally_and_finish;
      end
    end
  endtask
  // caller is at a falling edge; valid stays up between bits
  task push(input b, input l);
    begin
      TX_VALID = 1'b1;
      TX_BIT = b;
      TX_LAST = l;
      chk("tx_ready", TX_READY, 1);
      @(posedge MCLK);
      @(negedge MCLK);
    end
  endtask
  initial begin : main
    reg [15:0] d;
    integer i, j, ones;
    repeat (12) @(negedge MCLK);
    RST = 1'b0;
    chk("cc1_oe_n", CC1_OE_N, 1);
    chk("cc2_oe_n", CC2_OE_N, 1);
    repeat (3) @(negedge MCLK);
    chk("flag", DEAD_BATT_FLAG, 1);
    chk("supply", MAIN_SUPPLY_INPUT_CLOSED, 0);
    DEAD_BATT_CLEAR = 1'b1;
    @(negedge MCLK);
    DEAD_BATT_CLEAR = 1'b0;
    repeat (2) @(negedge MCLK);
    chk("flag", DEAD_BATT_FLAG, 0);
    chk("supply", MAIN_SUPPLY_INPUT_CLOSED, 1);
    $display("test dead battery done");
    d = nxt();
    ORIENT_CC2 = d[0];
    ATTACHED = 1'b1;
    @(negedge MCLK);
    d = nxt();
    ones = 0;
    edges = 0;
    seen_active = 1'b0;
    for (i = 0; i < 16; i = i + 1) begin
      push(d[i], i == 15);
      ones = ones + d[i];
    end
    TX_VALID = 1'b0;
    wait_idle(40000);
    chk("tx_edges", edges, 64 + 32 + 16 + ones);
    chk("own_active", seen_active, 1);
    $display("test transmit done");
    for (i = 0; i < 2; i = i + 1) begin
      ATTACHED = 1'b0;
      @(negedge MCLK);
      ORIENT_CC2 = ~ORIENT_CC2;
      ATTACHED = 1'b1;
      d = nxt();
      rxq.delete();
      seen_active = 1'b0;
      bmc_far_port_i.send(d, 8, i == 1);
      wait_idle(5000);
      chk("rx_active", seen_active, 1);
      chk("rx_count", rxq.size() >= 8, 1);
      if (rxq.size() >= 8)
        for (j = 0; j < 8; j = j + 1) chk("rx_bit", rxq[rxq.size() - 8 + j], d[j]);
      chk("rx_overrun", seen_ovr, 0);
      $display("test receive %0d done", i);
    end
    // second reset, strap says supply present
    DEAD_BATT_AT_BOOT = 1'b0;
    RST = 1'b1;
    repeat (2) @(negedge MCLK);
    RST = 1'b0;
    chk("cc1_oe_n", CC1_OE_N, 1);
    chk("cc2_oe_n", CC2_OE_N, 1);
    repeat (2) @(negedge MCLK);
    chk("flag", DEAD_BATT_FLAG, 0);
    chk("supply", MAIN_SUPPLY_INPUT_CLOSED, 1);
    $display("test normal boot done");
    tally_and_finish;
  end
endmodule // tb_top
